// [design/rfc_pkg.sv]
package rfc_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned RFC_DW    = 16;
    localparam int unsigned RFC_PCW   = 20;
    localparam int unsigned RFC_FLGW  = 11;
    localparam int unsigned RFC_BW    = 8;
    localparam int unsigned RFC_AW    = 8;
    localparam int unsigned RFC_IDX_L = 2;

    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int unsigned RFC_FLG_C = 0;
    localparam int unsigned RFC_FLG_D = 1;
    localparam int unsigned RFC_FLG_Z = 2;
    localparam int unsigned RFC_FLG_S = 3;
    localparam int unsigned RFC_FLG_B = 4;
    localparam int unsigned RFC_FLG_O = 5;
    localparam int unsigned RFC_FLG_U = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RFC_RST_WORD = 16'h0000;
    localparam logic [19:0] RFC_RST_PC   = 20'h00000;
    localparam logic [10:0] RFC_RST_FLG  = 11'h000;

    // ------------------------------------------------------------
    // operand codes; apb byte offset is code times four
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        RFC_DATA0   = 5'h00,
        RFC_DATA1   = 5'h01,
        RFC_DATA2   = 5'h02,
        RFC_DATA3   = 5'h03,
        RFC_ADDR0   = 5'h04,
        RFC_ADDR1   = 5'h05,
        RFC_FB      = 5'h06,
        RFC_SB      = 5'h07,
        RFC_VTB     = 5'h08,
        RFC_PC      = 5'h09,
        RFC_USP     = 5'h0a,
        RFC_ISP     = 5'h0b,
        RFC_FLG     = 5'h0c,
        RFC_SP      = 5'h0d,
        RFC_D0_UPR  = 5'h0e,
        RFC_D0_LWR  = 5'h0f,
        RFC_D1_UPR  = 5'h10,
        RFC_D1_LWR  = 5'h11,
        RFC_DPAIR_L = 5'h12,
        RFC_DPAIR_H = 5'h13,
        RFC_APAIR   = 5'h14
    } rfc_code_t;

    localparam logic [5:0] RFC_IDX_LAST = 6'h14;

    typedef enum logic [1:0] {
        RFC_SZ_BYTE = 2'b00,
        RFC_SZ_WORD = 2'b01,
        RFC_SZ_LONG = 2'b10
    } rfc_size_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0][15:0] data;
        logic [1:0][15:0] addr;
        logic [15:0]      fb;
    } rfc_bank_t;

    typedef struct packed {
        rfc_bank_t [1:0] bank;
        logic [15:0]     sb;
        logic [19:0]     vtb;
        logic [19:0]     pc;
        logic [15:0]     user_stack_pointer;
        logic [15:0]     irq_stack_pointer;
        logic [10:0]     cpu_state_flags;
        logic [31:0]     prdata;
        logic [31:0]     eurd;
    } rfc_state_t;

endpackage : rfc_pkg

// [design/rfc_regfile.sv]
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module rfc_regfile (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_clk_en,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic [4:0]  i_eu_sel,
    input  wire logic        i_eu_we,
    input  wire logic [31:0] i_eu_wdata,
    output logic [31:0]      o_eu_rdata,
    input  wire logic        i_pc_we,
    input  wire logic [19:0] i_pc_next,
    input  wire logic        i_alu_upd,
    input  wire logic [1:0]  i_alu_size,
    input  wire logic [31:0] i_alu_res,
    input  wire logic        i_alu_carry,
    input  wire logic        i_alu_ovf,
    output logic [19:0]      o_pc,
    output logic [19:0]      o_vector_table_base,
    output logic [15:0]      o_frame_base,
    output logic [15:0]      o_static_base,
    output logic [15:0]      o_active_sp,
    output logic [31:0]      o_addr_pair_32,
    output logic             o_bank,
    output logic [10:0]      o_cpu_state_flags
);

    // ------------------------------------------------------------
    // register read and write helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] get(input rfc_pkg::rfc_state_t s,
                                        input logic b,
                                        input logic [4:0] c);
        logic [31:0] r;
        r = '0;
        case (rfc_pkg::rfc_code_t'(c))
            rfc_pkg::RFC_DATA0:   r[15:0] = s.bank[b].data[0];
            rfc_pkg::RFC_DATA1:   r[15:0] = s.bank[b].data[1];
            rfc_pkg::RFC_DATA2:   r[15:0] = s.bank[b].data[2];
            rfc_pkg::RFC_DATA3:   r[15:0] = s.bank[b].data[3];
            rfc_pkg::RFC_ADDR0:   r[15:0] = s.bank[b].addr[0];
            rfc_pkg::RFC_ADDR1:   r[15:0] = s.bank[b].addr[1];
            rfc_pkg::RFC_FB:      r[15:0] = s.bank[b].fb;
            rfc_pkg::RFC_SB:      r[15:0] = s.sb;
            rfc_pkg::RFC_VTB:     r[19:0] = s.vtb;
            rfc_pkg::RFC_PC:      r[19:0] = s.pc;
            rfc_pkg::RFC_USP:     r[15:0] = s.user_stack_pointer;
            rfc_pkg::RFC_ISP:     r[15:0] = s.irq_stack_pointer;
            rfc_pkg::RFC_FLG:     r[10:0] = s.cpu_state_flags;
            rfc_pkg::RFC_SP:      r[15:0] =
                s.cpu_state_flags[rfc_pkg::RFC_FLG_U] ? s.user_stack_pointer : s.irq_stack_pointer;
            rfc_pkg::RFC_D0_UPR:  r[7:0] = s.bank[b].data[0][15:8];
            rfc_pkg::RFC_D0_LWR:  r[7:0] = s.bank[b].data[0][7:0];
            rfc_pkg::RFC_D1_UPR:  r[7:0] = s.bank[b].data[1][15:8];
            rfc_pkg::RFC_D1_LWR:  r[7:0] = s.bank[b].data[1][7:0];
            rfc_pkg::RFC_DPAIR_L:
                r = {s.bank[b].data[2], s.bank[b].data[0]};
            rfc_pkg::RFC_DPAIR_H:
                r = {s.bank[b].data[3], s.bank[b].data[1]};
            rfc_pkg::RFC_APAIR:
                r = {s.bank[b].addr[1], s.bank[b].addr[0]};
            default:              r = '0;
        endcase
        return r;
    endfunction : get

    function automatic rfc_pkg::rfc_state_t put(
        input rfc_pkg::rfc_state_t s,
        input logic b,
        input logic [4:0] c,
        input logic [31:0] v);
        rfc_pkg::rfc_state_t n;
        n = s;
        // only the bank named by the flag is touched
        case (rfc_pkg::rfc_code_t'(c))
            rfc_pkg::RFC_DATA0:   n.bank[b].data[0] = v[15:0];
            rfc_pkg::RFC_DATA1:   n.bank[b].data[1] = v[15:0];
            rfc_pkg::RFC_DATA2:   n.bank[b].data[2] = v[15:0];
            rfc_pkg::RFC_DATA3:   n.bank[b].data[3] = v[15:0];
            rfc_pkg::RFC_ADDR0:   n.bank[b].addr[0] = v[15:0];
            rfc_pkg::RFC_ADDR1:   n.bank[b].addr[1] = v[15:0];
            rfc_pkg::RFC_FB:      n.bank[b].fb = v[15:0];
            rfc_pkg::RFC_SB:      n.sb = v[15:0];
            rfc_pkg::RFC_VTB:     n.vtb = v[19:0];
            rfc_pkg::RFC_PC:      n.pc = v[19:0];
            rfc_pkg::RFC_USP:     n.user_stack_pointer = v[15:0];
            rfc_pkg::RFC_ISP:     n.irq_stack_pointer = v[15:0];
            rfc_pkg::RFC_FLG:     n.cpu_state_flags = v[10:0];
            rfc_pkg::RFC_SP: begin
                if (s.cpu_state_flags[rfc_pkg::RFC_FLG_U]) begin
                    n.user_stack_pointer = v[15:0];
                end else begin
                    n.irq_stack_pointer = v[15:0];
                end
            end
            rfc_pkg::RFC_D0_UPR:  n.bank[b].data[0][15:8] = v[7:0];
            rfc_pkg::RFC_D0_LWR:  n.bank[b].data[0][7:0] = v[7:0];
            rfc_pkg::RFC_D1_UPR:  n.bank[b].data[1][15:8] = v[7:0];
            rfc_pkg::RFC_D1_LWR:  n.bank[b].data[1][7:0] = v[7:0];
            rfc_pkg::RFC_DPAIR_L: begin
                n.bank[b].data[2] = v[31:16];
                n.bank[b].data[0] = v[15:0];
            end
            rfc_pkg::RFC_DPAIR_H: begin
                n.bank[b].data[3] = v[31:16];
                n.bank[b].data[1] = v[15:0];
            end
            rfc_pkg::RFC_APAIR: begin
                n.bank[b].addr[1] = v[31:16];
                n.bank[b].addr[0] = v[15:0];
            end
            default: n = s;
        endcase
        return n;
    endfunction : put

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    rfc_pkg::rfc_state_t s_q;
    rfc_pkg::rfc_state_t s_d;
    logic [5:0]          apb_idx;
    logic                apb_ok;
    logic                apb_setup;
    logic                apb_wr;
    logic                bank;

    assign apb_idx   = i_paddr[7:rfc_pkg::RFC_IDX_L];
    assign apb_ok    = (apb_idx <= rfc_pkg::RFC_IDX_LAST);
    assign apb_setup = i_psel && !i_penable;
    // zero wait state; a frozen clock enable holds the access phase
    assign apb_wr    = i_psel && i_penable && i_pwrite && apb_ok && i_clk_en;
    assign bank      = s_q.cpu_state_flags[rfc_pkg::RFC_FLG_B];

    assign o_pready  = i_clk_en;
    assign o_pslverr = i_psel && i_penable && !apb_ok;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (apb_setup) begin
            s_d.prdata = apb_ok ? get(s_q, bank, apb_idx[4:0]) : '0;
        end
        if (apb_wr) begin
            s_d = put(s_d, bank, apb_idx[4:0], i_pwdata);
        end
        // execution unit wins over a same-cycle bus write
        if (i_eu_we) begin
            s_d = put(s_d, bank, i_eu_sel, i_eu_wdata);
        end
        if (i_pc_we) begin
            s_d.pc = i_pc_next;
        end
        if (i_alu_upd) begin
            s_d.cpu_state_flags[rfc_pkg::RFC_FLG_C] = i_alu_carry;
            s_d.cpu_state_flags[rfc_pkg::RFC_FLG_O] = i_alu_ovf;
            case (rfc_pkg::rfc_size_t'(i_alu_size))
                rfc_pkg::RFC_SZ_BYTE: begin
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_Z] = (i_alu_res[7:0] == '0);
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_S] = i_alu_res[7];
                end
                rfc_pkg::RFC_SZ_WORD: begin
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_Z] = (i_alu_res[15:0] == '0);
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_S] = i_alu_res[15];
                end
                default: begin
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_Z] = (i_alu_res == '0);
                    s_d.cpu_state_flags[rfc_pkg::RFC_FLG_S] = i_alu_res[31];
                end
            endcase
        end
        s_d.eurd = get(s_q, bank, i_eu_sel);
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_prdata            = s_q.prdata;
    assign o_eu_rdata          = s_q.eurd;
    assign o_pc                = s_q.pc;
    assign o_vector_table_base = s_q.vtb;
    assign o_frame_base        = s_q.bank[bank].fb;
    assign o_static_base       = s_q.sb;
    assign o_active_sp         = s_q.cpu_state_flags[rfc_pkg::RFC_FLG_U] ? s_q.user_stack_pointer
                                                             : s_q.irq_stack_pointer;
    assign o_addr_pair_32      = {s_q.bank[bank].addr[1],
                                  s_q.bank[bank].addr[0]};
    assign o_bank              = bank;
    assign o_cpu_state_flags   = s_q.cpu_state_flags;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    sequence alu_word_zero;
        i_clk_en && i_alu_upd && i_alu_size == 2'b01
            && i_alu_res[15:0] == 16'h0000;
    endsequence

    sequence eu_wr_d0;
        i_clk_en && i_eu_we && i_eu_sel == 5'h00 && !apb_wr;
    endsequence

    chk_zero_flag: assert property (
        alu_word_zero |=> o_cpu_state_flags[2])
        else $error("zero flag not set on zero word result");

    chk_zero_clear: assert property (
        i_clk_en && i_alu_upd && i_alu_size == 2'b10 && i_alu_res != 0
            |=> !o_cpu_state_flags[2])
        else $error("zero flag set on nonzero result");

    chk_sign_flag: assert property (
        i_clk_en && i_alu_upd && i_alu_size == 2'b00
            |=> o_cpu_state_flags[3] == $past(i_alu_res[7]))
        else $error("sign flag differs from byte result msb");

    chk_carry_capture: assert property (
        i_clk_en && i_alu_upd
            |=> o_cpu_state_flags[0] == $past(i_alu_carry))
        else $error("carry flag did not capture alu carry");

    chk_ovf_flag: assert property (
        i_clk_en && i_alu_upd
            |=> o_cpu_state_flags[5] == $past(i_alu_ovf))
        else $error("overflow flag did not capture alu overflow");

    chk_pc_load: assert property (
        i_clk_en && i_pc_we |=> o_pc == $past(i_pc_next))
        else $error("program counter not loaded");

    chk_sp_select: assert property (
        i_clk_en && i_eu_we && i_eu_sel == 5'h0d && !i_alu_upd
            && !apb_wr
            |=> o_active_sp == $past(i_eu_wdata[15:0]))
        else $error("active stack pointer write lost");

    chk_pair_read: assert property (
        i_clk_en && i_eu_sel == 5'h12
            |=> o_eu_rdata == $past({s_q.bank[bank].data[2],
                                     s_q.bank[bank].data[0]}))
        else $error("data pair read wrong order");

    chk_byte_write: assert property (
        i_clk_en && i_eu_we && i_eu_sel == 5'h0e && !apb_wr
            |=> s_q.bank[bank].data[0][7:0]
                == $past(s_q.bank[bank].data[0][7:0]))
        else $error("upper byte write disturbed lower byte");

    chk_bank_split: assert property (
        eu_wr_d0 ##0 (!i_alu_upd)
            |=> $stable(s_q.bank[!bank].data[0]))
        else $error("write reached the inactive bank");

    chk_apb_unmapped: assert property (
        i_psel && i_penable && !apb_ok |-> o_pslverr && !apb_wr)
        else $error("unmapped apb access not refused");

    // ------------------------------------------------------------
    // write paths
    // ------------------------------------------------------------
    // a bus write is only trusted when the execution unit leaves the
    // same register alone, since the unit wins a same-cycle clash
    sequence apb_wr_vtb;
        apb_wr && apb_idx[4:0] == rfc_pkg::RFC_VTB
            && !(i_eu_we && i_eu_sel == rfc_pkg::RFC_VTB);
    endsequence

    sequence eu_wr_sb;
        i_clk_en && i_eu_we && i_eu_sel == rfc_pkg::RFC_SB;
    endsequence

    sequence eu_wr_apair;
        i_clk_en && i_eu_we && i_eu_sel == rfc_pkg::RFC_APAIR && !apb_wr;
    endsequence

    sequence eu_wr_fb;
        i_clk_en && i_eu_we && i_eu_sel == rfc_pkg::RFC_FB && !apb_wr;
    endsequence

    chk_vtb_write: assert property (
        apb_wr_vtb |=> o_vector_table_base == $past(i_pwdata[19:0]))
        else $error("bus write to table base lost");

    chk_sb_write: assert property (
        eu_wr_sb |=> o_static_base == $past(i_eu_wdata[15:0]))
        else $error("static base write lost");

    chk_apair_write: assert property (
        eu_wr_apair |=> o_addr_pair_32 == $past(i_eu_wdata))
        else $error("address pair write lost");

    chk_fb_write: assert property (
        eu_wr_fb |=> o_frame_base == $past(i_eu_wdata[15:0]))
        else $error("frame base write lost");

    // a low enable must hold every register, or a stalled pipe would
    // see values move under it
    chk_freeze_hold: assert property (
        !i_clk_en |=> $stable(o_cpu_state_flags) && $stable(o_pc)
            && $stable(o_static_base))
        else $error("state moved while clock enable was low");

endmodule : rfc_regfile

`default_nettype wire

// [dv/cpu_register_file_flags_bench.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------
// bench
// ------------------------
module cpu_register_file_flags_bench;
    logic        clk, nrst, en, psel, pen, pwr, pready, pslverr, err;
    logic        eu_we, pc_we, go, upd, carry, ovf, bank;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, eu_wdata, eu_rdata, a, b, res, apair, r;
    logic [4:0]  eu_sel;
    logic [19:0] pc_next, pc, vtb;
    logic [1:0]  size, asize;
    logic [15:0] fb, sb, sp;
    logic [10:0] cpu_state_flags;
    int          n_errors, n_checks;

    rfc_regfile uut (.i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(en),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_eu_sel(eu_sel), .i_eu_we(eu_we),
        .i_eu_wdata(eu_wdata), .o_eu_rdata(eu_rdata), .i_pc_we(pc_we),
        .i_pc_next(pc_next), .i_alu_upd(upd), .i_alu_size(size),
        .i_alu_res(res), .i_alu_carry(carry), .i_alu_ovf(ovf), .o_pc(pc),
        .o_vector_table_base(vtb), .o_frame_base(fb), .o_static_base(sb),
        .o_active_sp(sp), .o_addr_pair_32(apair), .o_bank(bank),
        .o_cpu_state_flags(cpu_state_flags));

    rfc_alu_model alu (.i_clk(clk), .i_go(go), .i_size(asize), .i_a(a),
        .i_b(b), .o_upd(upd), .o_size(size), .o_res(res), .o_carry(carry),
        .o_ovf(ovf));

    task summarize;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_errors++;
            summarize();
        end
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk(nm, e, r);
    endtask : rd

    task eu_w(input logic [4:0] c, input logic [31:0] d);
        eu_sel <= c;
        eu_wdata <= d;
        eu_we <= 1'b1;
        @(posedge clk);
        eu_we <= 1'b0;
        @(posedge clk);
    endtask : eu_w

    task eu_r(input string nm, input logic [4:0] c, input logic [31:0] e);
        eu_sel <= c;
        repeat (2) @(posedge clk);
        chk(nm, e, eu_rdata);
    endtask : eu_r

    task t_widths;
        logic [7:0]  off [7] = '{8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20,
                                 8'h24, 8'h2c};
        logic [31:0] ex  [7] = '{32'hffff, 32'hffff, 32'hffff, 32'hffff,
                                 32'hfffff, 32'hfffff, 32'hffff};
        chk("flags_rst", 32'h0, {21'h0, cpu_state_flags});
        rd("data0_rst", 8'h00, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, off[i], 32'hffffffff);
            rd("width", off[i], ex[i]);
        end
        chk("vtb", 32'hfffff, {12'h0, vtb});
        chk("sb", 32'hffff, {16'h0, sb});
        apb(1'b1, 8'h30, 32'hfffffffd);
        rd("flg_width", 8'h30, 32'h7fd);
        apb(1'b1, 8'h30, 32'h0);
        pc_next <= 20'habcde;
        pc_we <= 1'b1;
        @(posedge clk);
        pc_we <= 1'b0;
        @(posedge clk);
        chk("pc", 32'habcde, {12'h0, pc});
    endtask : t_widths

    task t_pairs;
        apb(1'b1, 8'h00, 32'h1234);
        apb(1'b1, 8'h04, 32'h5678);
        apb(1'b1, 8'h08, 32'habcd);
        apb(1'b1, 8'h0c, 32'h9abc);
        eu_r("pair_l", 5'h12, 32'habcd1234);
        eu_r("pair_h", 5'h13, 32'h9abc5678);
        rd("d0_upr", 8'h38, 32'h12);
        rd("d0_lwr", 8'h3c, 32'h34);
        apb(1'b1, 8'h38, 32'h55);
        rd("d0_after", 8'h00, 32'h5534);
        eu_w(5'h11, 32'hee);
        rd("d1_after", 8'h04, 32'h56ee);
        apb(1'b1, 8'h10, 32'h0a0a);
        apb(1'b1, 8'h14, 32'h0b0b);
        chk("apair", 32'h0b0b0a0a, apair);
        eu_w(5'h14, 32'hc3c33c3c);
        rd("a1", 8'h14, 32'hc3c3);
        rd("a0", 8'h10, 32'h3c3c);
        chk("slverr_last", 32'h0, {31'h0, err});
        rd("unmapped", 8'h54, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
    endtask : t_pairs

    task t_stack_bank;
        apb(1'b1, 8'h28, 32'h1111);
        apb(1'b1, 8'h2c, 32'h2222);
        apb(1'b1, 8'h30, 32'h080);
        chk("sp_user", 32'h1111, {16'h0, sp});
        rd("sp_code", 8'h34, 32'h1111);
        apb(1'b1, 8'h30, 32'h010);
        chk("sp_irq", 32'h2222, {16'h0, sp});
        chk("bank1", 32'h1, {31'h0, bank});
        apb(1'b1, 8'h00, 32'h7777);
        apb(1'b1, 8'h18, 32'h0f0f);
        rd("d0_bank1", 8'h00, 32'h7777);
        chk("fb_bank1", 32'h0f0f, {16'h0, fb});
        apb(1'b1, 8'h30, 32'h0);
        rd("d0_bank0", 8'h00, 32'h5534);
        chk("fb_bank0", 32'hffff, {16'h0, fb});
    endtask : t_stack_bank

    task alu_op(input logic [1:0] sz, input logic [31:0] x,
                input logic [31:0] y, input logic [3:0] e);
        asize <= sz;
        a <= x;
        b <= y;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        chk("osz_flags", {28'h0, e}, {28'h0, cpu_state_flags[rfc_pkg::RFC_FLG_O],
            cpu_state_flags[rfc_pkg::RFC_FLG_S], cpu_state_flags[rfc_pkg::RFC_FLG_Z],
            cpu_state_flags[rfc_pkg::RFC_FLG_C]});
    endtask : alu_op

    task t_alu;
        alu_op(2'b01, 32'h7fff, 32'h1, 4'b1100);
        alu_op(2'b01, 32'hffff, 32'h1, 4'b0011);
        alu_op(2'b00, 32'h7f, 32'h1, 4'b1100);
        alu_op(2'b10, 32'hffffffff, 32'h1, 4'b0011);
        alu_op(2'b01, 32'h1, 32'h1, 4'b0000);
    endtask : t_alu

    task t_freeze;
        en <= 1'b0;
        eu_w(5'h07, 32'h5a5a);
        chk("pready_frozen", 32'h0, {31'h0, pready});
        chk("sb_frozen", 32'hffff, {16'h0, sb});
        en <= 1'b1;
        eu_w(5'h07, 32'h5a5a);
        chk("sb_eu", 32'h5a5a, {16'h0, sb});
        eu_w(5'h06, 32'h0c0c);
        chk("fb_eu", 32'h0c0c, {16'h0, fb});
        eu_w(5'h0e, 32'h66);
        rd("d0_upr_eu", 8'h00, 32'h6634);
        eu_w(5'h0d, 32'h4444);
        chk("sp_eu", 32'h4444, {16'h0, sp});
    endtask : t_freeze

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        {nrst, psel, pen, pwr, eu_we, pc_we, go} = '0;
        {paddr, pwdata, eu_wdata, eu_sel, pc_next, a, b, asize} = '0;
        en = 1'b1;
        n_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_widths();
        t_pairs();
        t_stack_bank();
        t_alu();
        t_freeze();
        summarize();
    end
endmodule : cpu_register_file_flags_bench
`default_nettype wire

// [dv/rfc_alu_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------
// alu side of the block
// ------------------------
module rfc_alu_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [1:0]  i_size,
    input  wire logic [31:0] i_a,
    input  wire logic [31:0] i_b,
    output logic             o_upd,
    output logic [1:0]       o_size,
    output logic [31:0]      o_res,
    output logic             o_carry,
    output logic             o_ovf
);
    logic [32:0] mask;
    logic [32:0] sum;
    int          w;
    always @(posedge i_clk) begin
        w = (i_size == 2'b00) ? 8 : (i_size == 2'b01) ? 16 : 32;
        mask = (33'h1 << w) - 33'h1;
        sum = ({1'b0, i_a} & mask) + ({1'b0, i_b} & mask);
        o_upd <= i_go;
        o_size <= i_size;
        // result is only meaningful with o_upd, so it scrambles otherwise
        o_res <= i_go ? (sum[31:0] & mask[31:0]) : ~o_res;
        o_carry <= sum[w];
        o_ovf <= (i_a[w-1] == i_b[w-1]) && (sum[w-1] != i_a[w-1]);
    end
endmodule : rfc_alu_model
`default_nettype wire
